// ==== verilog/lsr_pkg.sv ====
// constants and types shared by the addressable shift register block
package lsr_pkg;
    localparam int SEG_BITS = 16;
    localparam int SEG_ADDR_W = 4;
    localparam int SEG_COUNT = 8;
    localparam int CHAIN_BITS = SEG_BITS * SEG_COUNT;
    localparam int CHAIN_ADDR_W = 7;
    localparam int ROM_GENS = 16;
    localparam int ROM_WORDS = SEG_BITS * ROM_GENS;
    localparam int ROM_ADDR_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    // rom depth modes, in words of one bit
    typedef enum logic [2:0] {
        LSR_ROM_DEPTH_16,
        LSR_ROM_DEPTH_32,
        LSR_ROM_DEPTH_64,
        LSR_ROM_DEPTH_128,
        LSR_ROM_DEPTH_256
    } lsr_rom_depth_t;
    // address masks and function generators used per depth
    localparam logic [7:0] ROM_MASK_16 = 8'h0f;
    localparam logic [7:0] ROM_MASK_32 = 8'h1f;
    localparam logic [7:0] ROM_MASK_64 = 8'h3f;
    localparam logic [7:0] ROM_MASK_128 = 8'h7f;
    localparam logic [7:0] ROM_MASK_256 = 8'hff;
    localparam logic [4:0] ROM_GENS_16 = 5'h01;
    localparam logic [4:0] ROM_GENS_32 = 5'h02;
    localparam logic [4:0] ROM_GENS_64 = 5'h04;
    localparam logic [4:0] ROM_GENS_128 = 5'h08;
    localparam logic [4:0] ROM_GENS_256 = 5'h10;
    localparam logic [255:0] ROM_INIT_DEFAULT = 256'h0;
    // one buffered word: the bit that left the tap and where it was taken
    typedef struct packed {
        logic data;
        logic [6:0] tap;
    } lsr_beat_t;
endpackage

// ==== verilog/lsr_top.sv ====
// 128-bit cascaded addressable shift register with rom mode
//
// What this block does
// - each 16-bit function generator shifts on the clock edge when enabled.
// - a 4-bit tap address picks any stored bit and may change at any time.
// - the shift contents have no set or reset of any kind.
// - the tapped bit is combinational, with an extra output flip-flop.
// - a cascade path moves the last bit of a segment into the next one.
// - eight cascaded segments give a 128-bit chain, any bit addressable.
// - rom mode gives 16 words per generator and depths 16 to 256 words.
// - rom depths use 1, 2, 4, 8 or 16 function generators.
// - rom contents are fixed at configuration and cascade deeper.
`timescale 1ns/1ns
module lsr_top
#(
    parameter logic [255:0] ROM_INIT = lsr_pkg::ROM_INIT_DEFAULT
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic in_data_i,
    output logic in_ready_o,
    input wire logic [lsr_pkg::CHAIN_ADDR_W-1:0] tap_addr_i,
    output logic tap_async_o,
    output logic tap_sync_o,
    output logic cascade_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output lsr_pkg::lsr_beat_t out_beat_o,
    input wire lsr_pkg::lsr_rom_depth_t rom_depth_i,
    input wire logic [lsr_pkg::ROM_ADDR_W-1:0] rom_addr_i,
    output logic rom_data_o,
    output logic [4:0] rom_gens_o
);
    import lsr_pkg::*;

    logic [CHAIN_BITS-1:0] chain_q;
    logic [SEG_COUNT-1:0] seg_tap;
    logic [SEG_COUNT-1:0] seg_in;
    logic [3:0] mux_a;
    logic [1:0] mux_b;
    logic mux_c;
    logic shift_en;
    logic tap_sync_q;
    lsr_beat_t buf_q [BUF_DEPTH];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic buf_push;
    logic buf_pop;
    lsr_beat_t push_beat;
    logic [7:0] rom_mask;
    logic [7:0] rom_eff_addr;

    // shifting is stalled while the buffer is full, so no tapped bit is lost
    assign in_ready_o = (count_q != BUF_FULL);
    assign shift_en = in_valid_i && in_ready_o;

    // segments: serial input feeds segment 0, each other one its neighbour
    genvar g;
    generate
        for (g = 0; g < SEG_COUNT; g++)
        begin : g_seg
            if (g == 0)
            begin : g_first
                assign seg_in[g] = in_data_i;
            end
            else
            begin : g_next
                // dedicated path, not the tapped output
                assign seg_in[g] = chain_q[g*SEG_BITS-1];
            end
            // no reset term: contents only change by shifting
            always_ff @(posedge clk_i)
            begin
                if (shift_en)
                begin
                    chain_q[g*SEG_BITS +: SEG_BITS] <=
                        {chain_q[g*SEG_BITS +: SEG_BITS-1], seg_in[g]};
                end
            end
            // per-generator 4-bit read port
            assign seg_tap[g] =
                chain_q[g*SEG_BITS + {28'h0, tap_addr_i[SEG_ADDR_W-1:0]}];
        end
    endgenerate

    // wide mux stages a, b, c combine the eight segment taps
    assign mux_a[0] = tap_addr_i[4] ? seg_tap[1] : seg_tap[0];
    assign mux_a[1] = tap_addr_i[4] ? seg_tap[3] : seg_tap[2];
    assign mux_a[2] = tap_addr_i[4] ? seg_tap[5] : seg_tap[4];
    assign mux_a[3] = tap_addr_i[4] ? seg_tap[7] : seg_tap[6];
    assign mux_b[0] = tap_addr_i[5] ? mux_a[1] : mux_a[0];
    assign mux_b[1] = tap_addr_i[5] ? mux_a[3] : mux_a[2];
    assign mux_c = tap_addr_i[6] ? mux_b[1] : mux_b[0];
    assign tap_async_o = mux_c;
    assign cascade_o = chain_q[CHAIN_BITS-1];

    // optional read flop; only meaningful with a steady address
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            tap_sync_q <= 1'b0;
        else
            tap_sync_q <= mux_c;
    end
    assign tap_sync_o = tap_sync_q;

    // two-entry buffer: bit leaving the tap on each shift, for the receiver
    assign push_beat.data = mux_c;
    assign push_beat.tap = tap_addr_i;
    assign buf_push = shift_en;
    assign buf_pop = out_valid_o && out_ready_i;
    assign out_valid_o = (count_q != 2'h0);
    assign out_beat_o = buf_q[rd_ptr_q];

    // pointers and fill level
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q ^ buf_push;
            rd_ptr_q <= rd_ptr_q ^ buf_pop;
            count_q <= count_q + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // buffer storage, cleared so the output is defined from reset
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end
        else if (buf_push)
        begin
            buf_q[wr_ptr_q] <= push_beat;
        end
    end

    // rom: depth picks how many generators the address reaches
    assign rom_mask = (rom_depth_i == LSR_ROM_DEPTH_16) ? ROM_MASK_16 :
                      (rom_depth_i == LSR_ROM_DEPTH_32) ? ROM_MASK_32 :
                      (rom_depth_i == LSR_ROM_DEPTH_64) ? ROM_MASK_64 :
                      (rom_depth_i == LSR_ROM_DEPTH_128) ? ROM_MASK_128 :
                      ROM_MASK_256;
    assign rom_gens_o = (rom_depth_i == LSR_ROM_DEPTH_16) ? ROM_GENS_16 :
                        (rom_depth_i == LSR_ROM_DEPTH_32) ? ROM_GENS_32 :
                        (rom_depth_i == LSR_ROM_DEPTH_64) ? ROM_GENS_64 :
                        (rom_depth_i == LSR_ROM_DEPTH_128) ? ROM_GENS_128 :
                        ROM_GENS_256;
    assign rom_eff_addr = rom_addr_i & rom_mask;
    // contents come only from the parameter; nothing can write them
    assign rom_data_o = ROM_INIT[rom_eff_addr];

    // checks
    sequence s_shift;
        in_valid_i && in_ready_o;
    endsequence

    // chain bits start unknown, so these compares must treat x as a value
    property p_shift_in;
        @(posedge clk_i) disable iff (rst_i)
        s_shift |=> chain_q[0] === $past(in_data_i);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("serial bit did not enter position zero");

    property p_shift_up;
        @(posedge clk_i) disable iff (rst_i)
        s_shift |=> chain_q[CHAIN_BITS-1:1] ===
            $past(chain_q[CHAIN_BITS-2:0]);
    endproperty
    a_shift_up: assert property (p_shift_up)
        else $error("stored bits did not move up by one");

    // no disable on reset: reset itself must leave the stored bits alone
    property p_hold;
        @(posedge clk_i)
        !(in_valid_i && in_ready_o) |=> chain_q === $past(chain_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("chain changed without an enabled shift");

    property p_cascade;
        @(posedge clk_i) disable iff (rst_i)
        s_shift |=> chain_q[SEG_BITS] === $past(chain_q[SEG_BITS-1]);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade bit lost between segments");

    property p_tap_async;
        @(posedge clk_i) disable iff (rst_i)
        tap_async_o === chain_q[tap_addr_i];
    endproperty
    a_tap_async: assert property (p_tap_async)
        else $error("tap output does not match addressed bit");

    property p_tap_sync;
        @(posedge clk_i) disable iff (rst_i)
        $stable(tap_addr_i) |=> tap_sync_o === $past(chain_q[tap_addr_i]);
    endproperty
    a_tap_sync: assert property (p_tap_sync)
        else $error("read flop missed the tapped bit");

    // two pushes with no pop fill the buffer, which must then refuse
    property p_stall;
        @(posedge clk_i) disable iff (rst_i)
        (in_valid_i && in_ready_o && !out_ready_i) [*2] |=> !in_ready_o;
    endproperty
    a_stall: assert property (p_stall)
        else $error("buffer accepted beyond two entries");

    property p_out_hold;
        @(posedge clk_i) disable iff (rst_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_beat_o);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("buffered word dropped under stall");

    property p_rom;
        @(posedge clk_i) disable iff (rst_i)
        rom_depth_i == LSR_ROM_DEPTH_16 |->
            rom_data_o == ROM_INIT[{4'h0, rom_addr_i[3:0]}] &&
            rom_gens_o == ROM_GENS_16;
    endproperty
    a_rom: assert property (p_rom)
        else $error("rom read wrong for 16-word depth");

    property p_rom_gens;
        @(posedge clk_i) disable iff (rst_i)
        rom_depth_i == LSR_ROM_DEPTH_256 |-> rom_gens_o == ROM_GENS_256 &&
            rom_data_o == ROM_INIT[rom_addr_i];
    endproperty
    a_rom_gens: assert property (p_rom_gens)
        else $error("rom 256-word depth wrong");
endmodule

// ==== test/lsr_sink.sv ====
// receiving user logic model that takes beats and can stall
`timescale 1ns/1ns
module lsr_sink
(
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire lsr_pkg::lsr_beat_t beat_i,
    output logic ready_o,
    output int taken_o
);
    import lsr_pkg::*;
    // slow mode holds ready low so the buffer must absorb words
    assign ready_o = !stall_i;
    initial taken_o = 0;
    // count every beat taken on a handshake edge
    always @(posedge clk_i)
    begin
        if (valid_i === 1'b1 && ready_o)
            taken_o <= taken_o + 1;
    end
endmodule

// ==== test/test_lut_addressable_shift_register.sv ====
// self-checking bench for the addressable shift register block
`timescale 1ns/1ns
module test_lut_addressable_shift_register;
    import lsr_pkg::*;
    localparam logic [255:0] ROM_PAT = {8{32'h9a3c_5e71}};
    localparam logic [127:0] PAT = 128'hf0e1_d2c3_b4a5_9687_7869_5a4b_3c2d_1e0f;
    logic clk_i = 0, rst_i = 1, in_valid_i = 0, in_data_i = 0, stall = 0;
    logic in_ready_o, tap_async_o, tap_sync_o, cascade_o, out_valid_o;
    logic out_ready_i, rom_data_o;
    logic [6:0] tap_addr_i = 7'h00;
    logic [7:0] rom_addr_i = 8'h00;
    logic [4:0] rom_gens_o;
    lsr_beat_t out_beat_o;
    lsr_rom_depth_t rom_depth_i = LSR_ROM_DEPTH_16;
    logic [127:0] exp_chain;
    int n_fail = 0, n_checks = 0, cyc = 0, taken;
    lsr_top #(.ROM_INIT(ROM_PAT)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .in_valid_i(in_valid_i), .in_data_i(in_data_i),
        .in_ready_o(in_ready_o), .tap_addr_i(tap_addr_i),
        .tap_async_o(tap_async_o), .tap_sync_o(tap_sync_o),
        .cascade_o(cascade_o), .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i), .out_beat_o(out_beat_o),
        .rom_depth_i(rom_depth_i), .rom_addr_i(rom_addr_i),
        .rom_data_o(rom_data_o), .rom_gens_o(rom_gens_o));
    lsr_sink sink_u (.clk_i(clk_i), .stall_i(stall), .valid_i(out_valid_o),
        .beat_i(out_beat_o), .ready_o(out_ready_i), .taken_o(taken));
    initial forever #2 clk_i = ~clk_i;
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", what, e, g);
            n_fail++;
        end
    endtask
    // offer one bit and hold it until accepted; valid stays high after
    task automatic push(input logic d);
        in_valid_i = 1'b1;
        in_data_i = d;
        @(posedge clk_i);
        while (in_ready_o !== 1'b1) @(posedge clk_i);
        #1;
        exp_chain = {exp_chain[126:0], d};
    endtask
    // fill all 128 bits back to back, then read every tap both ways
    task automatic t_fill();
        for (int i = 0; i < 128; i++) push(PAT[i]);
        in_valid_i = 1'b0;
        chk("cascade", exp_chain[127], cascade_o);
        for (int a = 0; a < 128; a++)
        begin
            tap_addr_i = 7'(a);
            #1 chk("tap_async", exp_chain[a], tap_async_o);
            @(posedge clk_i);
            #1 chk("tap_sync", exp_chain[a], tap_sync_o);
        end
        chk("beats", 8'h80, 8'(taken));
        $display("test fill done");
    endtask
    // receiver stalls: a full buffer must freeze the chain
    task automatic t_stall();
        stall = 1'b1;
        tap_addr_i = 7'h00;
        push(1'b1);
        push(1'b0);
        in_data_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1 chk("ready_full", 1'b0, in_ready_o);
        chk("held_bit", exp_chain[0], tap_async_o);
        chk("out_valid", 1'b1, out_valid_o);
        chk("beat", {exp_chain[2], 7'h00}, out_beat_o);
        stall = 1'b0;
        push(1'b1);
        in_valid_i = 1'b0;
        chk("after_stall", exp_chain[1:0], tap_async_o ? 2'h1 : 2'h0);
        $display("test stall done");
    endtask
    // every depth: masked word and generator count
    task automatic t_rom();
        for (int d = 0; d < 5; d++)
        begin
            rom_depth_i = lsr_rom_depth_t'(d);
            for (int a = 0; a < 256; a += 37)
            begin
                @(posedge clk_i);
                #1 rom_addr_i = 8'(a) | 8'h0f;
                #1 chk("rom_data", ROM_PAT[rom_addr_i & 8'((16 << d) - 1)],
                    rom_data_o);
            end
            chk("rom_gens", 8'(1 << d), 8'(rom_gens_o));
        end
        $display("test rom done");
    endtask
    // reset in mid-run must leave the stored bits alone
    task automatic t_reset();
        @(posedge clk_i);
        #1 rst_i = 1'b1;
        @(posedge clk_i);
        #1 chk("rst_ready", 1'b1, in_ready_o);
        chk("rst_sync", 1'b0, tap_sync_o);
        rst_i = 1'b0;
        for (int a = 0; a < 128; a += 9)
        begin
            @(posedge clk_i);
            #1 tap_addr_i = 7'(a);
            #1 chk("kept_bit", exp_chain[a], tap_async_o);
        end
        $display("test reset done");
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        #1 rst_i = 1'b0;
        t_fill();
        t_stall();
        t_rom();
        t_reset();
        end_of_test();
    end
endmodule
